// >>> clock_select_pkg.sv
// Constants, register map and mode encodings for the clock source selector.
// Notes on behaviour
// - Three-bit field selects one of eight modes.
// - Internal oscillator runs at 4 or 8 MHz.
// - Crystal modes wait 1024 input oscillations.
// - Start-up count follows power-up timer or wake.
// - Hold execution while start-up count runs.
// - Internal modes wait the warm-up delay.
// - External clock mode adds no start-up delay.
// - External clock enters on input pin; output pin freed.
// - Stopped clock halts logic, state kept intact.
// - RC mode drives output pin with Fosc/4.
// - Pin-free RC mode frees the output pin.
// - Internal clock-out mode drives Fosc/4, frees input.
// - Pin-free internal mode frees both pins.
// - Crystal modes set low, medium, high gain.
// - One bit chooses the internal frequency.
package clock_select_pkg;
  // Mode codes held in the low three bits of the configuration register.
  typedef enum logic [2:0] {
    low_power_crystal_mode           = 3'h0,
    medium_gain_crystal_mode         = 3'h1,
    high_gain_crystal_mode           = 3'h2,
    external_clock_input_mode        = 3'h3,
    internal_osc_pin_free_mode       = 3'h4,
    internal_osc_with_clock_output   = 3'h5,
    resistor_capacitor_pin_free_mode = 3'h6,
    resistor_capacitor_mode          = 3'h7
  } clock_mode_t;

  // Amplifier gain levels driven to the analog inverter.
  localparam logic [1:0] GAIN_OFF  = 2'h0;
  localparam logic [1:0] GAIN_LOW  = 2'h1;
  localparam logic [1:0] GAIN_MID  = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // Register byte addresses on APB.
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // Configuration fields and reset value.
  localparam int          MODE_LSB       = 0;
  localparam int          TIMER_EN_BIT   = 3;
  localparam int          FREQ_SEL_BIT   = 7;
  localparam logic [7:0]  CONFIG_RESET   = 8'h03;
  localparam logic [31:0] CONFIG_MASK    = 32'h0000_008F;

  // Timing figures.
  localparam int CLK_MHZ          = 250;
  localparam int INT_OSC_LOW_MHZ      = 4;
  localparam int INT_OSC_HIGH_MHZ     = 8;
  localparam int STARTUP_OSCILLATIONS = 1024;
  localparam int RC_DELAY_TICKS   = 8;
  localparam int WARMUP_NS        = 2000;
  localparam int WARMUP_CYCLES    = (WARMUP_NS * CLK_MHZ + 999) / 1000;
  localparam int COUNT_W          = 16;
endpackage : clock_select_pkg

// >>> startup_count_if.sv
// Interface between the start-up sequencer and its counter.
`timescale 1ns/1ps
interface startup_count_if #(parameter int W = 16);
  logic         start;
  logic         tick;
  logic [W-1:0] limit;
  logic         done;
  modport sequencer (output start, output tick, output limit, input done);
  modport counter (input start, input tick, input limit, output done);
endinterface : startup_count_if

// >>> oscillator_startup_counter.sv
// Counter that measures a start-up delay in ticks of a chosen enable.
`timescale 1ns/1ps
module oscillator_startup_counter (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Sequencer side
  startup_count_if.counter cnt
);
  logic [$bits(cnt.limit)-1:0] count;
  logic                        busy;

  // A start reloads the count; done rises once limit ticks have passed.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (cnt.start) begin
      count <= '0;
      busy  <= 1'b1;
    end else if (busy && cnt.tick) begin
      count <= count + 1'b1;
      if (count + 1'b1 >= cnt.limit) begin
        busy <= 1'b0;
      end
    end
  end

  assign cnt.done = !busy && !cnt.start;
endmodule : oscillator_startup_counter

// >>> clock_source_selector.sv
// Clock source selector: mode decode, pin roles, Fosc/4 and start-up hold.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
module clock_source_selector #(
  parameter int WARMUP_COUNT = clock_select_pkg::WARMUP_CYCLES
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Power and sleep events from the core
  input  wire logic                     power_up_timer_expired,
  input  wire logic                     sleep_enter,
  input  wire logic                     wake_event,
  // Oscillator pins
  input  wire logic                     oscillator_input_pin,
  input  wire logic                     oscillator_output_pin_i,
  output logic                          oscillator_output_pin_o,
  output logic                          oscillator_output_pin_oe,
  // Pin role and analog controls
  output logic                          input_pin_is_gpio,
  output logic                          output_pin_is_gpio,
  output logic [1:0]                    amp_gain,
  output logic                          internal_osc_enable,
  output logic                          internal_frequency_select,
  // Core clocking
  output logic                          fosc_tick,
  output logic                          cpu_hold
);
  import clock_select_pkg::*;

  // Refuse a warm-up count that the start-up counter cannot hold.
  if (WARMUP_COUNT < 1 || WARMUP_COUNT >= (1 << COUNT_W)) begin : g_bad_warmup
    $error("WARMUP_COUNT out of range for the start-up counter");
  end

  typedef enum logic [2:0] {
    st_wait_timer,
    st_startup,
    st_run,
    st_sleep
  } seq_state_t;

  // Configuration register.
  logic [7:0]  config_q;
  clock_mode_t mode;
  logic        timer_en;

  assign mode                      = clock_mode_t'(config_q[MODE_LSB +: 3]);
  assign timer_en                  = config_q[TIMER_EN_BIT];
  assign internal_frequency_select = config_q[FREQ_SEL_BIT];

  // Mode decode, kept as named wires so every pin role is visible at a glance.
  logic is_crystal;
  logic is_ext_clock;
  logic is_rc_any;
  logic is_int_any;
  logic drives_div_clock;

  assign is_crystal = (mode == low_power_crystal_mode) ||
                      (mode == medium_gain_crystal_mode) ||
                      (mode == high_gain_crystal_mode);
  assign is_ext_clock = (mode == external_clock_input_mode);
  assign is_rc_any  = (mode == resistor_capacitor_mode) ||
                      (mode == resistor_capacitor_pin_free_mode);
  assign is_int_any = (mode == internal_osc_with_clock_output) ||
                      (mode == internal_osc_pin_free_mode);
  assign drives_div_clock = (mode == resistor_capacitor_mode) ||
                         (mode == internal_osc_with_clock_output);

  // Input pin is free only in internal modes; output pin in external-clock and both pin-free modes.
  assign input_pin_is_gpio  = is_int_any;
  assign output_pin_is_gpio = is_ext_clock ||
                              (mode == resistor_capacitor_pin_free_mode) ||
                              (mode == internal_osc_pin_free_mode);
  assign internal_osc_enable = is_int_any;

  // Amplifier gain follows the crystal mode and is off for all others.
  always_comb begin
    case (mode)
      low_power_crystal_mode:   amp_gain = GAIN_LOW;
      medium_gain_crystal_mode: amp_gain = GAIN_MID;
      high_gain_crystal_mode:   amp_gain = GAIN_HIGH;
      default:                  amp_gain = GAIN_OFF;
    endcase
  end

  // Input pin synchroniser; a level counts once stages two and three agree.
  logic sync1;
  logic sync2;
  logic sync3;
  logic pin_level;
  logic next_pin_level;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= oscillator_input_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign next_pin_level = (sync2 == sync3) ? sync3 : pin_level;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_level <= 1'b0;
    end else begin
      pin_level <= next_pin_level;
    end
  end

  // Internal oscillator: a phase accumulator gives an exact average rate
  // since neither 4 MHz nor 8 MHz divides the 250 MHz clock evenly.
  localparam logic [8:0] ACC_WRAP = 9'(CLK_MHZ);
  localparam logic [8:0] INC_LOW  = 9'(INT_OSC_LOW_MHZ);
  localparam logic [8:0] INC_HIGH = 9'(INT_OSC_HIGH_MHZ);

  logic [8:0] phase_acc;
  logic [8:0] phase_inc;
  logic [8:0] phase_sum;
  logic       int_wrap;

  assign phase_inc = internal_frequency_select ? INC_HIGH : INC_LOW;
  assign phase_sum = phase_acc + phase_inc;
  assign int_wrap  = is_int_any && (phase_sum >= ACC_WRAP);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_acc <= '0;
    end else if (!is_int_any) begin
      phase_acc <= '0;
    end else if (int_wrap) begin
      phase_acc <= phase_sum - ACC_WRAP;
    end else begin
      phase_acc <= phase_sum;
    end
  end

  // One oscillator tick per rising edge of the pin, or per accumulator wrap.
  // Outside the internal modes no edge on the pin means no tick, so the Fosc/4 divider and the start-up count below stand still.
  logic ext_edge;
  logic next_tick;

  assign ext_edge  = !is_int_any && next_pin_level && !pin_level;
  assign next_tick = ext_edge || int_wrap;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fosc_tick <= 1'b0;
    end else begin
      fosc_tick <= next_tick;
    end
  end

  // Fosc/4 on the output pin: toggle every second oscillator tick.
  logic [1:0] div_cnt;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_cnt                 <= '0;
      oscillator_output_pin_o <= 1'b0;
    end else if (!drives_div_clock) begin
      div_cnt                 <= '0;
      oscillator_output_pin_o <= 1'b0;
    end else if (fosc_tick) begin
      div_cnt <= div_cnt + 1'b1;
      if (div_cnt[0]) begin
        oscillator_output_pin_o <= !oscillator_output_pin_o;
      end
    end
  end

  assign oscillator_output_pin_oe = drives_div_clock;

  // Start-up sequencer and its counter.
  startup_count_if #(.W(COUNT_W)) cnt_if ();

  oscillator_startup_counter u_counter (
    .mclk   (mclk),
    .resetn (resetn),
    .cnt    (cnt_if.counter)
  );

  seq_state_t   state;
  seq_state_t   next_state;
  logic         start_now;
  logic         use_mclk_tick;
  logic [COUNT_W-1:0] delay_limit;

  // Crystals count pin oscillations, RC counts two instruction cycles,
  // internal modes count the warm-up time in system clock cycles.
  always_comb begin
    if (is_crystal) begin
      delay_limit = COUNT_W'(STARTUP_OSCILLATIONS);
    end else if (is_rc_any) begin
      delay_limit = COUNT_W'(RC_DELAY_TICKS);
    end else begin
      delay_limit = COUNT_W'(WARMUP_COUNT);
    end
  end

  assign use_mclk_tick = is_int_any;
  assign cnt_if.limit  = delay_limit;
  assign cnt_if.tick   = use_mclk_tick ? 1'b1 : fosc_tick;
  assign cnt_if.start  = start_now;

  // Leaving reset or sleep starts a count unless the clock is external.
  always_comb begin
    next_state = state;
    start_now  = 1'b0;
    case (state)
      st_wait_timer: begin
        if (!timer_en || power_up_timer_expired) begin
          if (is_ext_clock) begin
            next_state = st_run;
          end else begin
            next_state = st_startup;
            start_now  = 1'b1;
          end
        end
      end
      st_startup: begin
        if (sleep_enter) begin
          next_state = st_sleep;
        end else if (cnt_if.done) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (sleep_enter) begin
          next_state = st_sleep;
        end
      end
      st_sleep: begin
        if (wake_event) begin
          if (is_ext_clock) begin
            next_state = st_run;
          end else begin
            next_state = st_startup;
            start_now  = 1'b1;
          end
        end
      end
      default: next_state = st_wait_timer;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= st_wait_timer;
    end else begin
      state <= next_state;
    end
  end

  assign cpu_hold = (state != st_run);

  // APB slave: zero wait states, read data captured in the setup cycle.
  logic        setup_phase;
  logic        access_wr;
  logic        hit_config;
  logic        hit_status;
  logic        mapped;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pwrite;
  assign hit_config  = (paddr == ADDR_CONFIG);
  assign hit_status  = (paddr == ADDR_STATUS);
  assign mapped      = hit_config || hit_status;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !mapped;

  assign status_word = {22'h0, output_pin_is_gpio, input_pin_is_gpio,
                        amp_gain, cnt_if.done, cpu_hold, 1'b0, 3'(state)};
  assign next_rdata  = hit_config ? {24'h0, config_q} :
                       hit_status ? status_word : 32'h0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
    end else if (setup_phase) begin
      prdata <= next_rdata;
    end
  end

  // Configuration writes; unused bits are masked so they read as zero.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      config_q <= CONFIG_RESET;
    end else if (access_wr && hit_config) begin
      config_q <= 8'(pwdata & CONFIG_MASK);
    end
  end
endmodule : clock_source_selector

// >>> osc_source_model.sv
// Behavioural oscillator source that drives the oscillator input pin.
`timescale 1ns/1ps
module osc_source_model (
  // Control from the bench
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  // Pin
  output logic            pin
);
  logic [3:0] cnt;

  // A stopped source rests low, so a halted clock shows no stray edge.
  initial begin
    pin = 1'b0;
    cnt = 4'h0;
  end

  // Square wave of two half periods while running; it starts over on restart.
  always @(posedge mclk) begin
    if (!run) begin
      cnt <= 4'h0;
      pin <= 1'b0;
    end else if (cnt + 4'h1 >= half) begin
      cnt <= 4'h0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : osc_source_model

// >>> clock_source_selector_assertions.sv
// Checker of pin roles, gain, register answers and start-up hold.
`timescale 1ns/1ps
module clock_source_selector_assertions (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Events, pins and controls
  input wire logic        wake_event,
  input wire logic        oscillator_input_pin,
  input wire logic        oscillator_output_pin_o,
  input wire logic        oscillator_output_pin_oe,
  input wire logic        input_pin_is_gpio,
  input wire logic        output_pin_is_gpio,
  input wire logic [1:0]  amp_gain,
  input wire logic        internal_osc_enable,
  input wire logic        internal_frequency_select,
  input wire logic        fosc_tick,
  input wire logic        cpu_hold
);
  import clock_select_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] cfg;
  logic [3:0] quiet;
  logic       pin_q;
  wire  [2:0] m = cfg[2:0];
  wire        acc = psel && penable;
  wire        mapped = paddr == ADDR_CONFIG || paddr == ADDR_STATUS;

  // Shadow of the configuration word, taken at the same access edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      cfg <= CONFIG_RESET;
    else if (acc && pwrite && paddr == ADDR_CONFIG)
      cfg <= pwdata[7:0];
  end

  // Cycles since the input pin last moved, saturating so it never wraps.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b0;
      quiet <= 4'h0;
    end else begin
      pin_q <= oscillator_input_pin;
      quiet <= (pin_q != oscillator_input_pin) ? 4'h0 : quiet + 4'(quiet != 4'hF);
    end
  end

  property p_gain;
    amp_gain == (m == 3'h0 ? GAIN_LOW : m == 3'h1 ? GAIN_MID : m == 3'h2 ? GAIN_HIGH : GAIN_OFF);
  endproperty
  a_gain: assert property (p_gain) else $error("gain level wrong for mode");
  property p_oe;
    oscillator_output_pin_oe == (m == 3'h5 || m == 3'h7);
  endproperty
  a_oe: assert property (p_oe) else $error("output pin drive wrong for mode");
  property p_in_gpio;
    input_pin_is_gpio == (m == 3'h4 || m == 3'h5);
  endproperty
  a_in_gpio: assert property (p_in_gpio) else $error("input pin role wrong");
  property p_out_gpio;
    output_pin_is_gpio == (m == 3'h3 || m == 3'h4 || m == 3'h6);
  endproperty
  a_out_gpio: assert property (p_out_gpio) else $error("output pin role wrong");
  property p_osc_en;
    internal_osc_enable == (m[2] && !m[1]) &&
      internal_frequency_select == cfg[FREQ_SEL_BIT];
  endproperty
  a_osc_en: assert property (p_osc_en) else $error("internal source controls wrong");
  property p_released;
    // The divided clock is a flop, so it rests low from the edge after the drive drops.
    !oscillator_output_pin_oe |=> !oscillator_output_pin_o;
  endproperty
  a_released: assert property (p_released) else $error("undriven output pin not low");
  property p_static;
    quiet == 4'hF && !internal_osc_enable && $past(!internal_osc_enable) |-> !fosc_tick;
  endproperty
  a_static: assert property (p_static) else $error("tick without input edges");
  property p_ext_wake;
    wake_event && cpu_hold && m == 3'h3 && !cfg[TIMER_EN_BIT] |-> ##[1:4] !cpu_hold;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("external clock wake delayed");
  property p_apb;
    acc |-> pready && pslverr == !mapped && (pwrite || mapped || prdata == 32'h0);
  endproperty
  a_apb: assert property (p_apb) else $error("register answer wrong");
  c_crystal: cover property ($fell(cpu_hold) && m == 3'h0);
  c_divclk: cover property (oscillator_output_pin_oe && $rose(oscillator_output_pin_o));
  c_refused: cover property (acc && pslverr);
endmodule : clock_source_selector_assertions

bind clock_source_selector clock_source_selector_assertions chk_u (
  .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wake_event(wake_event), .oscillator_input_pin(oscillator_input_pin),
  .oscillator_output_pin_o(oscillator_output_pin_o),
  .oscillator_output_pin_oe(oscillator_output_pin_oe), .input_pin_is_gpio(input_pin_is_gpio),
  .output_pin_is_gpio(output_pin_is_gpio), .amp_gain(amp_gain),
  .internal_osc_enable(internal_osc_enable),
  .internal_frequency_select(internal_frequency_select),
  .fosc_tick(fosc_tick), .cpu_hold(cpu_hold)
);

// >>> clock_source_selector_tb.sv
// Testbench for the clock source selector.
`timescale 1ns/1ps
module clock_source_selector_tb;
  import clock_select_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sleep_enter = 1'b0, wake_event = 1'b0, timer_done = 1'b0, run = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  half = 4'h3;
  logic        pready, pslverr, pin_in, pin_o, pin_oe, in_gpio, out_gpio, err, pin_q;
  logic        osc_en, freq_sel, fosc_tick, cpu_hold;
  logic [1:0]  amp_gain;
  int          fail_count = 0, checked = 0, ticks = 0, rises = 0;
  // A released output pin is pulled high on the board.
  wire         pin_i = pin_oe ? pin_o : 1'b1;

  clock_source_selector #(.WARMUP_COUNT(4)) dut_u (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_up_timer_expired(timer_done), .sleep_enter(sleep_enter), .wake_event(wake_event),
    .oscillator_input_pin(pin_in), .oscillator_output_pin_i(pin_i),
    .oscillator_output_pin_o(pin_o), .oscillator_output_pin_oe(pin_oe),
    .input_pin_is_gpio(in_gpio), .output_pin_is_gpio(out_gpio), .amp_gain(amp_gain),
    .internal_osc_enable(osc_en), .internal_frequency_select(freq_sel),
    .fosc_tick(fosc_tick), .cpu_hold(cpu_hold)
  );
  osc_source_model src_u (.mclk(mclk), .run(run), .half(half), .pin(pin_in));

  // Clock, and running counts of oscillator ticks and divided-clock rises.
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    pin_q <= pin_o;
    ticks <= ticks + int'(fosc_tick === 1'b1);
    rises <= rises + int'(pin_o === 1'b1 && pin_q === 1'b0);
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : apb

  // Sleep with the source halted, check the hold, then wake and restart it.
  task automatic sleep_wake(output int t0);
    @(posedge mclk);
    sleep_enter <= 1'b1;
    run <= 1'b0;
    @(posedge mclk);
    sleep_enter <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd & 32'h17, 32'h13);
    wake_event <= 1'b1;
    @(posedge mclk);
    // Base count as of the edge that starts the counter; stray stop ticks fall before it.
    t0 = ticks + int'(fosc_tick === 1'b1);
    wake_event <= 1'b0;
    run <= 1'b1;
  endtask : sleep_wake

  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40000) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_run

  task automatic t_regs();
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd & 32'h31F, 32'h202);
    apb(1'b1, ADDR_CONFIG, 32'hFFFFFFFF);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check(rd, 32'h8F);
    apb(1'b1, 8'h08, 32'h1);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    check(rd | 32'(!err), 32'h0);
  endtask : t_regs

  task automatic t_modes();
    logic [1:0] g;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, ADDR_CONFIG, 32'(m));
      apb(1'b0, ADDR_STATUS, 32'h0);
      g = m < 3 ? 2'(m + 1) : 2'h0;
      check(32'(rd[9:6]), 32'({m == 3 || m == 4 || m == 6, m == 4 || m == 5, g}));
      check(32'({pin_oe, osc_en, amp_gain}), 32'({m == 5 || m == 7, m == 4 || m == 5, g}));
    end
  endtask : t_modes

  task automatic t_crystal();
    int t0;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, ADDR_CONFIG, 32'(m));
      sleep_wake(t0);
      if (m == 1) begin
        repeat (300) @(posedge mclk);
        run <= 1'b0;
        repeat (100) @(posedge mclk);
        check(32'(cpu_hold), 32'h1);
        run <= 1'b1;
      end
      wait_run();
      check(32'(ticks - t0), 32'h400);
    end
  endtask : t_crystal

  // Divided clock must rise once per four ticks, within one of phase.
  task automatic quarter(input int t0, input int r0);
    int q;
    q = (rises - r0) * 4;
    check(32'(q >= ticks - t0 - 4 && q <= ticks - t0 + 4), 32'h1);
  endtask : quarter

  task automatic t_rc();
    int t0;
    int r0;
    apb(1'b1, ADDR_CONFIG, 32'h7);
    sleep_wake(t0);
    wait_run();
    check(32'(ticks - t0), 32'h8);
    r0 = rises;
    t0 = ticks;
    repeat (480) @(posedge mclk);
    quarter(t0, r0);
  endtask : t_rc

  task automatic t_fast();
    int t0;
    int r0;
    int n;
    apb(1'b1, ADDR_CONFIG, 32'h3);
    sleep_wake(t0);
    repeat (4) @(posedge mclk);
    check(32'(cpu_hold), 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'h4);
    sleep_wake(t0);
    @(posedge mclk);
    check(32'(cpu_hold), 32'h1);
    repeat (8) @(posedge mclk);
    check(32'(cpu_hold), 32'h0);
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, ADDR_CONFIG, f ? 32'h85 : 32'h5);
      // The written word shows only after the access edge has settled.
      @(posedge mclk);
      check(32'(freq_sel), 32'(f));
      t0 = ticks;
      r0 = rises;
      repeat (1000) @(posedge mclk);
      n = ticks - t0;
      check(32'(n >= 15 + 16 * f && n <= 17 + 16 * f), 32'h1);
      quarter(t0, r0);
    end
  endtask : t_fast

  // Reset for four cycles, then each scenario in turn.
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    timer_done <= 1'b1;
    repeat (4) @(posedge mclk);
    t_regs();
    t_modes();
    t_crystal();
    t_rc();
    t_fast();
    stop_test();
  end
endmodule : clock_source_selector_tb
